//--- src/event_queue_consts.vh
`ifndef EVENT_QUEUE_CONSTS_VH
`define EVENT_QUEUE_CONSTS_VH

// Queue geometry
`define QUEUE_DEPTH          160
`define PER_INPUT_LIMIT      10
`define INPUT_COUNT          16
`define INPUT_INDEX_WIDTH    4
`define SEQUENCE_WIDTH       8
`define STAMP_WIDTH          32
`define COUNT_WIDTH          8
`define SLOT_INDEX_WIDTH     8

// Register offsets (word addresses)
`define OFF_CONTROL          4'h0
`define OFF_ACK              4'h1
`define OFF_EVENT_SEQ        4'h2
`define OFF_EVENT_INFO       4'h3
`define OFF_EVENT_STAMP      4'h4
`define OFF_PENDING          4'h5
`define OFF_LIVE             4'h6
`define OFF_CAPTURE_CFG      4'h7

// Control and capture configuration register fields
`define CTRL_PER_INPUT_BIT   0
`define CTRL_CLEAR_BIT       1
`define CTRL_SEL_LSB         4
`define CTRL_SEL_MSB         7
`define CFG_HOLD_BIT         16

// Update interval in microseconds, clock rate in MHz
`define UPDATE_INTERVAL_US   1000
`define CLOCK_MHZ            20

`endif

//--- src/rate_divider.v
`timescale 1ns/10ps
// One-cycle enable every PERIOD clocks
module rate_divider #(
    parameter PERIOD = 20000
) (
    input  wire        clock,
    input  wire        rstn,
    output reg         tick
);
    reg [31:0] count_q;

    always @(posedge clock) begin
        if (!rstn) begin
            count_q <= 32'h0;
            tick    <= 1'b0;
        end else if (count_q == PERIOD - 1) begin
            count_q <= 32'h0;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + 32'h1;
            tick    <= 1'b0;
        end
    end
endmodule // rate_divider

//--- src/input_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser; change accepted when stages two and three agree
module input_sync #(
    parameter WIDTH = 16
) (
    input  wire [WIDTH-1:0] clock_in_d,
    input  wire             clock,
    input  wire             rstn,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer i;

    always @(posedge clock) begin
        if (!rstn) begin
            s1_q     <= {WIDTH{1'b0}};
            s2_q     <= {WIDTH{1'b0}};
            s3_q     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            s1_q <= clock_in_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // input_sync

//--- src/event_timestamp_queue_retrieval.v
`timescale 1ns/10ps
`include "event_queue_consts.vh"

module event_timestamp_queue_retrieval #(
    parameter DEPTH          = `QUEUE_DEPTH,
    parameter PER_LIMIT      = `PER_INPUT_LIMIT,
    parameter UPDATE_CYCLES  = `UPDATE_INTERVAL_US * `CLOCK_MHZ
) (
    input  wire        clock,
    input  wire        rstn,
    input  wire [15:0] input_pins,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest
);
    ////////////////////////////////////////////////////////////////////////
    // Update tick, input sampling, free-running time base
    wire        update_tick;
    wire [15:0] live_inputs;
    reg  [15:0] prev_inputs_q;
    reg  [31:0] time_q;

    rate_divider #(
        .PERIOD (UPDATE_CYCLES)
    ) u_div (
        .clock (clock),
        .rstn  (rstn),
        .tick  (update_tick)
    );

    input_sync #(
        .WIDTH (16)
    ) u_sync (
        .clock_in_d (input_pins),
        .clock      (clock),
        .rstn       (rstn),
        .sync_out   (live_inputs)
    );

    ////////////////////////////////////////////////////////////////////////
    // Controller-written fields (ack, clear and mode select act at the update tick)
    reg        per_input_retrieval_select_q;
    reg        clear_all_events_request_q;
    reg [3:0]  selected_input_index_q;
    reg [7:0]  event_acknowledge_value_q;
    reg [15:0] input_capture_enable_q;
    reg        hold_timestamp_until_cleared_q;
    reg        mode_active_q;
    reg        clear_seen_q;
    reg [7:0]  ack_seen_q;

    ////////////////////////////////////////////////////////////////////////
    // Queue storage
    reg                  slot_valid_q [0:DEPTH-1];
    reg [3:0]            slot_input_q [0:DEPTH-1];
    reg                  slot_dir_q   [0:DEPTH-1];
    reg [31:0]           slot_stamp_q [0:DEPTH-1];
    reg [7:0]            slot_seq_q   [0:DEPTH-1];
    reg [7:0]            pending_event_count_q;
    reg [7:0]            next_seq_q;
    // Wide enough for a full queue of one input in time order
    reg [7:0]            per_input_count_q [0:15];

    reg [7:0]  current_event_sequence_q;
    reg [3:0]  event_input_index_q;
    reg        event_direction_q;
    reg [31:0] current_stamp_q;
    reg        current_valid_q;

    // Head search: earliest valid slot, filtered by input in per-input mode
    reg        found;
    reg [7:0]  head_idx;
    integer    k;
    always @* begin
        found    = 1'b0;
        head_idx = 8'h0;
        for (k = 0; k < DEPTH; k = k + 1) begin
            if (!found && slot_valid_q[k] &&
                (!mode_active_q || slot_input_q[k] == selected_input_index_q)) begin
                found    = 1'b1;
                head_idx = k[7:0];
            end
        end
    end

    // New transition and admission checks
    reg        cap_hit;
    reg [3:0]  cap_idx;
    integer    n;
    always @* begin
        cap_hit = 1'b0;
        cap_idx = 4'h0;
        for (n = 15; n >= 0; n = n - 1) begin
            if (input_capture_enable_q[n] && (live_inputs[n] != prev_inputs_q[n])) begin
                cap_hit = 1'b1;
                cap_idx = n[3:0];
            end
        end
    end

    wire queue_has_room = (pending_event_count_q < DEPTH[7:0]);
    wire under_limit = !mode_active_q ||
                       (per_input_count_q[cap_idx] < PER_LIMIT[7:0]);
    wire hold_ok = !hold_timestamp_until_cleared_q ||
                   (per_input_count_q[cap_idx] == 8'h0);
    wire admit   = cap_hit && queue_has_room && under_limit && hold_ok;

    wire ack_now    = update_tick && current_valid_q &&
                      (event_acknowledge_value_q == current_event_sequence_q) &&
                      (ack_seen_q != event_acknowledge_value_q);
    wire clear_now  = update_tick && clear_all_events_request_q && !clear_seen_q;
    // Queue stays packed from slot 0, so the write slot follows from the count
    wire [7:0] wr_idx = ack_now ? pending_event_count_q - 8'h1 : pending_event_count_q;

    ////////////////////////////////////////////////////////////////////////
    // Queue update
    integer m;
    always @(posedge clock) begin
        if (!rstn) begin
            for (m = 0; m < DEPTH; m = m + 1) begin
                slot_valid_q[m] <= 1'b0;
                slot_input_q[m] <= 4'h0;
                slot_dir_q[m]   <= 1'b0;
                slot_stamp_q[m] <= 32'h0;
                slot_seq_q[m]   <= 8'h0;
            end
            for (m = 0; m < 16; m = m + 1) begin
                per_input_count_q[m] <= 8'h0;
            end
            pending_event_count_q    <= 8'h0;
            next_seq_q               <= 8'h1;
            prev_inputs_q            <= 16'h0;
            time_q                   <= 32'h0;
            mode_active_q            <= 1'b0;
            clear_seen_q             <= 1'b0;
            ack_seen_q               <= 8'h0;
            current_event_sequence_q <= 8'h0;
            event_input_index_q      <= 4'h0;
            event_direction_q        <= 1'b0;
            current_stamp_q          <= 32'h0;
            current_valid_q          <= 1'b0;
        end else begin
            time_q        <= time_q + 32'h1;
            prev_inputs_q <= live_inputs;
            if (update_tick) begin
                clear_seen_q <= clear_all_events_request_q;
                ack_seen_q   <= event_acknowledge_value_q;
            end
            if (clear_now) begin
                for (m = 0; m < DEPTH; m = m + 1) begin
                    slot_valid_q[m] <= 1'b0;
                end
                for (m = 0; m < 16; m = m + 1) begin
                    per_input_count_q[m] <= 8'h0;
                end
                pending_event_count_q <= 8'h0;
                mode_active_q         <= per_input_retrieval_select_q;
            end else begin
                // acknowledge retires current event
                // Later slots close up: slot order stays time order, no wrap
                for (m = 0; m < DEPTH; m = m + 1) begin
                    if (ack_now && m >= head_idx) begin
                        if (m == DEPTH - 1) begin
                            slot_valid_q[m] <= 1'b0;
                        end else begin
                            slot_valid_q[m] <= slot_valid_q[m + 1];
                            slot_input_q[m] <= slot_input_q[m + 1];
                            slot_dir_q[m]   <= slot_dir_q[m + 1];
                            slot_stamp_q[m] <= slot_stamp_q[m + 1];
                            slot_seq_q[m]   <= slot_seq_q[m + 1];
                        end
                    end
                end
                // capture into shared queue
                // After the shift, so a same-cycle capture wins its slot
                if (admit) begin
                    slot_valid_q[wr_idx] <= 1'b1;
                    slot_input_q[wr_idx] <= cap_idx;
                    slot_dir_q[wr_idx]   <= live_inputs[cap_idx];
                    slot_stamp_q[wr_idx] <= time_q;
                    slot_seq_q[wr_idx]   <= next_seq_q;
                    next_seq_q <= (next_seq_q == 8'hff) ? 8'h1 : next_seq_q + 8'h1;
                end
                if (admit && !ack_now) begin
                    pending_event_count_q <= pending_event_count_q + 8'h1;
                end else if (!admit && ack_now) begin
                    pending_event_count_q <= pending_event_count_q - 8'h1;
                end
                for (m = 0; m < 16; m = m + 1) begin
                    if (admit && cap_idx == m[3:0] &&
                        !(ack_now && slot_input_q[head_idx] == m[3:0])) begin
                        per_input_count_q[m] <= per_input_count_q[m] + 8'h1;
                    end else if (!(admit && cap_idx == m[3:0]) && ack_now &&
                                 slot_input_q[head_idx] == m[3:0]) begin
                        per_input_count_q[m] <= per_input_count_q[m] - 8'h1;
                    end
                end
                if (update_tick && pending_event_count_q == 8'h0 && !admit) begin
                    mode_active_q <= per_input_retrieval_select_q;
                end
            end
            if (update_tick) begin
                if (clear_now || !found) begin
                    current_valid_q          <= 1'b0;
                    current_event_sequence_q <= 8'h0;
                    event_input_index_q      <= 4'h0;
                    event_direction_q        <= 1'b0;
                    current_stamp_q          <= 32'h0;
                end else if (!ack_now) begin
                    current_valid_q          <= 1'b1;
                    current_event_sequence_q <= slot_seq_q[head_idx];
                    event_input_index_q      <= slot_input_q[head_idx];
                    event_direction_q        <= slot_dir_q[head_idx];
                    current_stamp_q          <= slot_stamp_q[head_idx];
                end else begin
                    // only on match; next shows next update
                    current_valid_q          <= 1'b0;
                    current_event_sequence_q <= 8'h0;
                    event_input_index_q      <= 4'h0;
                    event_direction_q        <= 1'b0;
                    current_stamp_q          <= 32'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave; reads stall one cycle so readdata stands at the answer edge
    reg        rd_done_q;
    assign avs_waitrequest = avs_read && !rd_done_q;

    always @(posedge clock) begin
        if (!rstn) begin
            per_input_retrieval_select_q   <= 1'b0;
            clear_all_events_request_q     <= 1'b0;
            selected_input_index_q         <= 4'h0;
            event_acknowledge_value_q      <= 8'h0;
            input_capture_enable_q         <= 16'hffff;
            hold_timestamp_until_cleared_q <= 1'b0;
        end else if (avs_write) begin
            case (avs_address)
                `OFF_CONTROL: begin
                    if (avs_byteenable[0]) begin
                        per_input_retrieval_select_q <= avs_writedata[`CTRL_PER_INPUT_BIT];
                        clear_all_events_request_q   <= avs_writedata[`CTRL_CLEAR_BIT];
                        selected_input_index_q <= avs_writedata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
                    end
                end
                `OFF_ACK: begin
                    if (avs_byteenable[0]) begin
                        event_acknowledge_value_q <= avs_writedata[7:0];
                    end
                end
                `OFF_CAPTURE_CFG: begin
                    if (avs_byteenable[0]) begin
                        input_capture_enable_q[7:0] <= avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        input_capture_enable_q[15:8] <= avs_writedata[15:8];
                    end
                    if (avs_byteenable[2]) begin
                        hold_timestamp_until_cleared_q <= avs_writedata[`CFG_HOLD_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clock) begin
        if (!rstn) begin
            avs_readdata <= 32'h0;
            rd_done_q    <= 1'b0;
        end else begin
            rd_done_q <= avs_waitrequest;
            if (avs_waitrequest) begin
            case (avs_address)
                `OFF_CONTROL:     avs_readdata <= {24'h0, selected_input_index_q, 1'b0,
                                                   mode_active_q, clear_all_events_request_q,
                                                   per_input_retrieval_select_q};
                `OFF_ACK:         avs_readdata <= {24'h0, event_acknowledge_value_q};
                `OFF_EVENT_SEQ:   avs_readdata <= {24'h0, current_event_sequence_q};
                `OFF_EVENT_INFO:  avs_readdata <= {23'h0, event_direction_q, 4'h0,
                                                   event_input_index_q};
                `OFF_EVENT_STAMP: avs_readdata <= current_stamp_q;
                `OFF_PENDING:     avs_readdata <= {24'h0, pending_event_count_q};
                `OFF_LIVE:        avs_readdata <= {16'h0, live_inputs};
                `OFF_CAPTURE_CFG: avs_readdata <= {15'h0, hold_timestamp_until_cleared_q,
                                                   input_capture_enable_q};
                default:          avs_readdata <= 32'h0;
            endcase
            end
        end
    end
endmodule // event_timestamp_queue_retrieval

//--- verification/field_inputs.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Field side: plain input levels; spacing leaves room for the synchroniser
module field_inputs (
    input  wire        clock,
    output reg  [15:0] pins
);
    initial pins = 16'h0000;

    task set_pin(input [3:0] idx, input v);
        @(posedge clock);
        pins[idx] <= v;
        repeat (4) @(posedge clock);
    endtask
endmodule // field_inputs

//--- verification/event_queue_asserts.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module eq_checker #(
    parameter DEPTH = 160
) (
    input  wire        clock,
    input  wire        rstn,
    input  wire [15:0] input_pins,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    input  wire [31:0] avs_readdata,
    input  wire        avs_waitrequest
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    no_wait_a: assert property (avs_write |-> avs_waitrequest == 1'b0)
        else $error("write stalled");
    read_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read stalled more than one cycle");
    data_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata))
        else $error("readdata moved without a read");
    unmapped_zero_a: assert property (avs_read && avs_address[3] |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    seq_width_a: assert property (avs_read && avs_address == 4'h2 |=> avs_readdata[31:8] == 24'h0)
        else $error("sequence field too wide");
    info_fields_a: assert property (avs_read && avs_address == 4'h3 |=>
        avs_readdata[31:9] == 23'h0 && avs_readdata[7:4] == 4'h0)
        else $error("event info out of range");
    pending_bound_a: assert property (avs_read && avs_address == 4'h5 |=> avs_readdata <= DEPTH)
        else $error("pending count above depth");
    live_width_a: assert property (avs_read && avs_address == 4'h6 |=> avs_readdata[31:16] == 16'h0)
        else $error("live view too wide");
    ctrl_width_a: assert property (avs_read && avs_address == 4'h0 |=> avs_readdata[31:8] == 24'h0)
        else $error("control readback too wide");
    reset_clean_a: assert property ($rose(rstn) |-> avs_readdata == 32'h0)
        else $error("readdata not zero after reset");
endmodule // eq_checker

bind event_timestamp_queue_retrieval eq_checker #(.DEPTH(DEPTH)) u_chk (
    .clock(clock), .rstn(rstn), .input_pins(input_pins), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

//--- verification/tb.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module tb;
    localparam UPD = 8;
    reg         clock = 1'b0;
    reg         rstn = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    wire [15:0] pins;
    wire [31:0] rdata;
    wire        wait_req;
    integer     err_count = 0;
    integer     cmp_count = 0;
    integer     cycles = 0;
    integer     i;
    reg  [31:0] d;

    always #25 clock = ~clock;

    field_inputs u_field (.clock(clock), .pins(pins));

    event_timestamp_queue_retrieval #(.UPDATE_CYCLES(UPD)) u_dut (
        .clock(clock), .rstn(rstn), .input_pins(pins), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_req));

    ////////////////////////////////////////////////////////////////////////////
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            print_verdict;
        end
    end

    task bus_write(input [3:0] a, input [31:0] v);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        @(posedge clock);
        while (wait_req !== 1'b0) @(posedge clock);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    // Read data taken at the edge where waitrequest is seen low
    task bus_read(input [3:0] a, output [31:0] v);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock);
        while (wait_req !== 1'b0) @(posedge clock);
        v = rdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask

    task chk(input [3:0] a, input [31:0] e, input string nm);
        bus_read(a, d);
        cmp_count = cmp_count + 1;
        if (d !== e) begin
            err_count = err_count + 1;
            $display("BAD %s expected %h seen %h", nm, e, d);
        end
    endtask

    task ticks(input integer n);
        repeat (n * UPD) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        chk(4'h0, 32'h0, "control");
        chk(4'h7, 32'hffff, "capture");
        chk(4'h2, 32'h0, "sequence");
        chk(4'h5, 32'h0, "pending");
        chk(4'h8, 32'h0, "unmapped");
        // Time order, refused and accepted acknowledge
        u_field.set_pin(4'd3, 1'b1);
        u_field.set_pin(4'd5, 1'b1);
        u_field.set_pin(4'd3, 1'b0);
        ticks(3);
        chk(4'h5, 32'h3, "pending");
        chk(4'h2, 32'h1, "sequence");
        chk(4'h3, 32'h103, "info");
        ticks(2);
        chk(4'h2, 32'h1, "sequence");
        bus_write(4'h1, 32'h2);
        ticks(3);
        chk(4'h2, 32'h1, "sequence");
        bus_write(4'h1, 32'h1);
        ticks(3);
        chk(4'h2, 32'h2, "sequence");
        chk(4'h3, 32'h105, "info");
        bus_write(4'h1, 32'h2);
        ticks(3);
        chk(4'h3, 32'h003, "info");
        bus_write(4'h1, 32'h3);
        ticks(3);
        chk(4'h2, 32'h0, "sequence");
        chk(4'h3, 32'h0, "info");
        // Per-input retrieval of input 5
        bus_write(4'h0, 32'h51);
        ticks(3);
        chk(4'h0, 32'h55, "control");
        u_field.set_pin(4'd2, 1'b1);
        u_field.set_pin(4'd5, 1'b0);
        u_field.set_pin(4'd2, 1'b0);
        u_field.set_pin(4'd5, 1'b1);
        ticks(3);
        chk(4'h2, 32'h5, "sequence");
        chk(4'h3, 32'h005, "info");
        bus_write(4'h1, 32'h5);
        ticks(3);
        chk(4'h2, 32'h7, "sequence");
        chk(4'h3, 32'h105, "info");
        bus_write(4'h1, 32'h7);
        ticks(3);
        chk(4'h2, 32'h0, "sequence");
        for (i = 0; i < 12; i = i + 1) u_field.set_pin(4'd6, (i % 2) == 0);
        ticks(3);
        chk(4'h5, 32'd12, "pending");
        // Clear-all with mode switch back to time order
        bus_write(4'h0, 32'h02);
        ticks(3);
        chk(4'h5, 32'h0, "pending");
        chk(4'h2, 32'h0, "sequence");
        chk(4'h3, 32'h0, "info");
        chk(4'h4, 32'h0, "stamp");
        chk(4'h6, 32'h0020, "live");
        chk(4'h0, 32'h02, "control");
        bus_write(4'h0, 32'h0);
        ticks(2);
        u_field.set_pin(4'd1, 1'b1);
        ticks(3);
        chk(4'h5, 32'h1, "pending");
        chk(4'h3, 32'h101, "info");
        // Mode change waits for an empty queue
        bus_write(4'h0, 32'h01);
        ticks(3);
        chk(4'h0, 32'h01, "control");
        bus_read(4'h2, d);
        bus_write(4'h1, d);
        ticks(3);
        chk(4'h0, 32'h05, "control");
        // Hold: uncleared data blocks the next change
        bus_write(4'h7, 32'h1ffff);
        u_field.set_pin(4'd9, 1'b1);
        u_field.set_pin(4'd9, 1'b0);
        ticks(3);
        chk(4'h5, 32'h1, "pending");
        chk(4'h7, 32'h1ffff, "capture");
        print_verdict;
    end
endmodule // tb
